// ===== inc/smbus_params.svh
`ifndef SMBUS_PARAMS_SVH
`define SMBUS_PARAMS_SVH

// Overview of operation
// - Slave enabled only when mode strap high
// - Four address straps added to the base address
// - Straps 0000 give address byte 0xB0
// - Address is 0x58 plus strap value
// - Address byte LSB: 0 write, 1 read
// - Driver holds SDA stable while SCL high
// - SDA falling with SCL high is START
// - SDA rising with SCL high is STOP
// - Bus idle after bus-free or max-high time
// - Acknowledge own address, register and data bytes
// - Host write: START, address, register, data, STOP
// - First byte after write address is register
// - Host read: register write, repeated START, read
// - Device returns register contents, MSB first
// - Host ends read with NACK then STOP

// Slave address
`define SMB_ADDR_BASE      7'h58
`define SMB_DIR_WRITE      1'b0
`define SMB_DIR_READ       1'b1

// Timing, in ns
`define SMB_T_BUF_NS       4700
`define SMB_T_HIGH_MAX_NS  50000
`define SMB_LINK_PERIOD_NS 125
`define SMB_CLK_PERIOD_NS  25
`define SMB_SCL_PERIOD_NS  10000

// Link cycles until the pin synchroniser shows strap levels after reset
`define SMB_STRAP_SETTLE   4'h2

`endif

// ===== inc/smbus_pkg.sv
package smbus_pkg;

  localparam int IDLE_CNT_W = 10;
  localparam int QCNT_W     = 8;

  typedef enum logic [3:0] {
    st_idle,
    st_addr,
    st_ack_addr,
    st_reg,
    st_ack_reg,
    st_wdata,
    st_ack_data,
    st_rdata,
    st_rack,
    st_ignore
  } dev_state_type;

  typedef enum logic [3:0] {
    seg_idle,
    seg_start,
    seg_addr_w,
    seg_reg,
    seg_data,
    seg_rstart,
    seg_addr_r,
    seg_rdata,
    seg_stop
  } host_seg_type;

  typedef struct packed {
    dev_state_type         st;
    logic [3:0]            cnt;
    logic [7:0]            shreg;
    logic                  rw;
    logic [7:0]            reg_addr;
    logic [7:0]            wr_data;
    logic                  wr_stb;
    logic                  rd_stb;
    logic                  sda_oe_n;
    logic                  drv_lo;
    logic                  scl_q;
    logic                  sda_q;
    logic [IDLE_CNT_W-1:0] idle_cnt;
    logic                  stop_seen;
    logic                  bus_idle;
    logic                  en;
    logic [6:0]            my_addr;
    logic                  strap_done;
  } dev_regs_type;

  typedef struct packed {
    host_seg_type      seg;
    logic [1:0]        q;
    logic [3:0]        bitn;
    logic [QCNT_W-1:0] qcnt;
    logic              rw;
    logic [6:0]        dev;
    logic [7:0]        regad;
    logic [7:0]        wdata;
    logic [7:0]        shreg;
    logic [7:0]        rdata;
    logic              busy;
    logic              done;
    logic              ack_err;
    logic              scl_oe_n;
    logic              sda_oe_n;
    logic              drv_lo;
  } host_regs_type;

endpackage

// ===== inc/smbus_if.sv
`timescale 1ns/1ps
interface smbus_if;
  // Host side drives
  logic scl_o_h;
  logic scl_oe_n_h;
  logic sda_o_h;
  logic sda_oe_n_h;
  // Device side drives
  logic sda_o_d;
  logic sda_oe_n_d;
  // Resolved wire levels with pull-ups
  logic scl;
  logic sda;

  assign scl = scl_oe_n_h | scl_o_h;
  assign sda = (sda_oe_n_h | sda_o_h) & (sda_oe_n_d | sda_o_d);

  modport host (
    output scl_o_h,
    output scl_oe_n_h,
    output sda_o_h,
    output sda_oe_n_h,
    input  scl,
    input  sda
  );

  modport device (
    output sda_o_d,
    output sda_oe_n_d,
    input  scl,
    input  sda
  );
endinterface

// ===== core/smbus_sync.sv
`timescale 1ns/1ps
module smbus_sync #(
  parameter int              WIDTH    = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_regs_type;

  sync_regs_type r;
  sync_regs_type r_nxt;

  if (WIDTH < 1) begin
    $error("smbus_sync: WIDTH must be at least 1");
  end

  always_comb begin
    r_nxt    = r;
    r_nxt.s1 = d;
    r_nxt.s2 = r.s1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '{s1: RST_VAL, s2: RST_VAL};
    end else begin
      r <= r_nxt;
    end
  end

  assign q = r.s2;
endmodule

// ===== core/smbus_device_end.sv
`timescale 1ns/1ps
`include "smbus_params.svh"
module smbus_device_end #(
  parameter int T_BUF_NS      = `SMB_T_BUF_NS,
  parameter int T_HIGH_MAX_NS = `SMB_T_HIGH_MAX_NS,
  parameter int LINK_NS       = `SMB_LINK_PERIOD_NS
) (
  // Link clock and reset
  input  wire logic        link_clk,
  input  wire logic        srst,
  // Straps
  input  wire logic        serial_mode_strap,
  input  wire logic [3:0]  addr_sel,
  // Bus
  smbus_if.device          bus,
  // Register side
  output logic      [7:0]  reg_addr,
  output logic      [7:0]  wr_data,
  output logic             wr_stb,
  input  wire logic [7:0]  rd_data,
  output logic             rd_stb,
  // Status
  output logic             bus_idle,
  output logic             slave_en
);
  import smbus_pkg::*;

  localparam int BUF_CYC_I  = (T_BUF_NS + LINK_NS - 1) / LINK_NS;
  localparam int HIGH_CYC_I = (T_HIGH_MAX_NS + LINK_NS - 1) / LINK_NS;
  localparam logic [IDLE_CNT_W-1:0] BUF_CYC  = IDLE_CNT_W'(BUF_CYC_I);
  localparam logic [IDLE_CNT_W-1:0] HIGH_CYC = IDLE_CNT_W'(HIGH_CYC_I);

  if (BUF_CYC_I < 1 || HIGH_CYC_I < 1 || BUF_CYC_I > HIGH_CYC_I) begin
    $error("smbus_device_end: bad idle timing parameters");
  end
  if (HIGH_CYC_I >= (1 << IDLE_CNT_W)) begin
    $error("smbus_device_end: idle counter too narrow");
  end

  dev_regs_type r;
  dev_regs_type r_nxt;

  logic [6:0] pins_s;
  logic       mode_s;
  logic [3:0] ad_s;
  logic       scl_s;
  logic       sda_s;

  // Pins into the link domain
  smbus_sync #(
    .WIDTH   (7),
    .RST_VAL (7'h03)
  ) u_sync (
    .clk  (link_clk),
    .srst (srst),
    .d    ({serial_mode_strap, addr_sel, bus.scl, bus.sda}),
    .q    (pins_s)
  );

  assign mode_s = pins_s[6];
  assign ad_s   = pins_s[5:2];
  assign scl_s  = pins_s[1];
  assign sda_s  = pins_s[0];

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  assign scl_rise = scl_s & ~r.scl_q;
  assign scl_fall = ~scl_s & r.scl_q;
  assign start_c  = r.scl_q & scl_s & r.sda_q & ~sda_s;
  assign stop_c   = r.scl_q & scl_s & ~r.sda_q & sda_s;

  always_comb begin
    r_nxt        = r;
    r_nxt.wr_stb = 1'b0;
    r_nxt.rd_stb = 1'b0;
    r_nxt.scl_q  = scl_s;
    r_nxt.sda_q  = sda_s;

    // Straps caught once; synchroniser shows its reset value first
    if (!r.strap_done) begin
      r_nxt.cnt = r.cnt + 4'h1;
      if (r.cnt == `SMB_STRAP_SETTLE) begin
        r_nxt.cnt        = 4'h0;
        r_nxt.strap_done = 1'b1;
        r_nxt.en         = mode_s;
        r_nxt.my_addr    = `SMB_ADDR_BASE + {3'b000, ad_s};
      end
    end

    // Idle timing
    if (scl_s && sda_s) begin
      if (r.idle_cnt != HIGH_CYC) begin
        r_nxt.idle_cnt = r.idle_cnt + 1'b1;
      end
    end else begin
      r_nxt.idle_cnt = '0;
    end
    if (stop_c) begin
      r_nxt.stop_seen = 1'b1;
    end else if (start_c) begin
      r_nxt.stop_seen = 1'b0;
    end
    r_nxt.bus_idle = (r.stop_seen && r.idle_cnt >= BUF_CYC) ||
                     (r.idle_cnt >= HIGH_CYC);

    if (!r.en || !r.strap_done) begin
      r_nxt.st       = st_idle;
      r_nxt.sda_oe_n = 1'b1;
    end else if (start_c) begin
      r_nxt.st       = st_addr;
      r_nxt.cnt      = 4'h0;
      r_nxt.sda_oe_n = 1'b1;
    end else if (stop_c || (r_nxt.bus_idle && !r.bus_idle)) begin
      r_nxt.st       = st_idle;
      r_nxt.sda_oe_n = 1'b1;
    end else begin
      unique case (r.st)
        st_idle, st_ignore: begin
          r_nxt.sda_oe_n = 1'b1;
        end
        st_addr, st_reg, st_wdata: begin
          if (scl_rise) begin
            r_nxt.shreg = {r.shreg[6:0], sda_s};
            r_nxt.cnt   = r.cnt + 4'h1;
          end else if (scl_fall && r.cnt == 4'h8) begin
            if (r.st == st_addr) begin
              if (r.shreg[7:1] == r.my_addr) begin
                r_nxt.rw       = r.shreg[0];
                r_nxt.sda_oe_n = 1'b0;
                r_nxt.st       = st_ack_addr;
              end else begin
                r_nxt.st = st_ignore;
              end
            end else if (r.st == st_reg) begin
              r_nxt.reg_addr = r.shreg;
              r_nxt.sda_oe_n = 1'b0;
              r_nxt.st       = st_ack_reg;
            end else begin
              r_nxt.wr_data  = r.shreg;
              r_nxt.wr_stb   = 1'b1;
              r_nxt.sda_oe_n = 1'b0;
              r_nxt.st       = st_ack_data;
            end
          end
        end
        st_ack_addr: begin
          if (scl_fall) begin
            r_nxt.cnt = 4'h0;
            if (r.rw == `SMB_DIR_READ) begin
              r_nxt.shreg    = rd_data;
              r_nxt.sda_oe_n = rd_data[7];
              r_nxt.rd_stb   = 1'b1;
              r_nxt.st       = st_rdata;
            end else begin
              r_nxt.sda_oe_n = 1'b1;
              r_nxt.st       = st_reg;
            end
          end
        end
        st_ack_reg: begin
          if (scl_fall) begin
            r_nxt.cnt      = 4'h0;
            r_nxt.sda_oe_n = 1'b1;
            r_nxt.st       = st_wdata;
          end
        end
        st_ack_data: begin
          // Single data byte per write
          if (scl_fall) begin
            r_nxt.sda_oe_n = 1'b1;
            r_nxt.st       = st_ignore;
          end
        end
        st_rdata: begin
          if (scl_rise) begin
            r_nxt.cnt = r.cnt + 4'h1;
          end else if (scl_fall) begin
            if (r.cnt == 4'h8) begin
              r_nxt.sda_oe_n = 1'b1;
              r_nxt.st       = st_rack;
            end else begin
              r_nxt.shreg    = {r.shreg[6:0], 1'b0};
              r_nxt.sda_oe_n = r.shreg[6];
            end
          end
        end
        st_rack: begin
          // Host acknowledge bit ends the single-byte read
          if (scl_rise) begin
            r_nxt.st = st_ignore;
          end
        end
      endcase
    end
  end

  always_ff @(posedge link_clk) begin
    if (srst) begin
      r <= '{st: st_idle, cnt: 4'h0, shreg: 8'h00, rw: 1'b0,
             reg_addr: 8'h00, wr_data: 8'h00, wr_stb: 1'b0, rd_stb: 1'b0,
             sda_oe_n: 1'b1, drv_lo: 1'b0, scl_q: 1'b1, sda_q: 1'b1,
             idle_cnt: '0, stop_seen: 1'b0, bus_idle: 1'b0, en: 1'b0,
             my_addr: 7'h00, strap_done: 1'b0};
    end else begin
      r <= r_nxt;
    end
  end

  // SCL is never driven from this end
  assign bus.sda_o_d    = r.drv_lo;
  assign bus.sda_oe_n_d = r.sda_oe_n;
  assign reg_addr       = r.reg_addr;
  assign wr_data        = r.wr_data;
  assign wr_stb         = r.wr_stb;
  assign rd_stb         = r.rd_stb;
  assign bus_idle       = r.bus_idle;
  assign slave_en       = r.en;
endmodule

// ===== core/smbus_host_end.sv
`timescale 1ns/1ps
`include "smbus_params.svh"
module smbus_host_end #(
  parameter int QUARTER = `SMB_SCL_PERIOD_NS / `SMB_CLK_PERIOD_NS / 4
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Command
  input  wire logic       cmd_valid,
  input  wire logic       cmd_rw,
  input  wire logic [6:0] cmd_dev,
  input  wire logic [7:0] cmd_reg,
  input  wire logic [7:0] cmd_wdata,
  // Answer
  output logic            busy,
  output logic            done,
  output logic [7:0]      rdata,
  output logic            ack_err,
  // Bus
  smbus_if.host           bus
);
  import smbus_pkg::*;

  localparam logic [QCNT_W-1:0] QLAST = QCNT_W'(QUARTER - 1);

  if (QUARTER < 2 || QUARTER > (1 << QCNT_W)) begin
    $error("smbus_host_end: QUARTER out of range");
  end

  host_regs_type r;
  host_regs_type r_nxt;
  logic          sda_s;
  logic          tick;
  logic          scl_lvl;
  logic          sda_lvl;

  smbus_sync #(
    .WIDTH   (1),
    .RST_VAL (1'b1)
  ) u_sync (
    .clk  (clk),
    .srst (srst),
    .d    (bus.sda),
    .q    (sda_s)
  );

  assign tick = (r.qcnt == QLAST);

  always_comb begin
    r_nxt      = r;
    r_nxt.done = 1'b0;
    scl_lvl    = 1'b1;
    sda_lvl    = 1'b1;
    if (r.seg == seg_idle) begin
      if (cmd_valid) begin
        r_nxt.seg     = seg_start;
        r_nxt.q       = 2'd0;
        r_nxt.qcnt    = '0;
        r_nxt.rw      = cmd_rw;
        r_nxt.dev     = cmd_dev;
        r_nxt.regad   = cmd_reg;
        r_nxt.wdata   = cmd_wdata;
        r_nxt.busy    = 1'b1;
        r_nxt.ack_err = 1'b0;
      end
    end else if (!tick) begin
      r_nxt.qcnt = r.qcnt + 1'b1;
    end else begin
      r_nxt.qcnt = '0;
      // Sample at end of first high quarter
      if (r.q == 2'd1 && r.bitn == 4'h8 && r.seg != seg_rdata) begin
        r_nxt.ack_err = sda_s;
      end
      if (r.q == 2'd1 && r.bitn != 4'h8 && r.seg == seg_rdata) begin
        r_nxt.rdata = {r.rdata[6:0], sda_s};
      end
      if (r.q != 2'd3) begin
        r_nxt.q = r.q + 2'd1;
      end else begin
        r_nxt.q = 2'd0;
        unique case (r.seg)
          seg_start, seg_rstart: begin
            r_nxt.bitn  = 4'h0;
            r_nxt.seg   = (r.seg == seg_start) ? seg_addr_w : seg_addr_r;
            r_nxt.shreg = {r.dev, (r.seg == seg_start) ?
                           `SMB_DIR_WRITE : `SMB_DIR_READ};
          end
          seg_stop: begin
            r_nxt.seg  = seg_idle;
            r_nxt.busy = 1'b0;
            r_nxt.done = 1'b1;
          end
          default: begin
            if (r.bitn != 4'h8) begin
              r_nxt.bitn  = r.bitn + 4'h1;
              r_nxt.shreg = {r.shreg[6:0], 1'b0};
            end else begin
              r_nxt.bitn = 4'h0;
              if (r.seg == seg_rdata || r_nxt.ack_err) begin
                r_nxt.seg = seg_stop;
              end else if (r.seg == seg_addr_w) begin
                r_nxt.seg   = seg_reg;
                r_nxt.shreg = r.regad;
              end else if (r.seg == seg_reg) begin
                r_nxt.seg   = r.rw ? seg_rstart : seg_data;
                r_nxt.shreg = r.wdata;
              end else if (r.seg == seg_addr_r) begin
                r_nxt.seg = seg_rdata;
              end else begin
                r_nxt.seg = seg_stop;
              end
            end
          end
        endcase
      end
    end

    // Levels of the quarter being entered
    unique case (r_nxt.seg)
      seg_idle: begin
        scl_lvl = 1'b1;
        sda_lvl = 1'b1;
      end
      seg_start, seg_rstart: begin
        scl_lvl = (r_nxt.q == 2'd1) || (r_nxt.q == 2'd2);
        sda_lvl = (r_nxt.q < 2'd2);
      end
      seg_stop: begin
        scl_lvl = (r_nxt.q != 2'd0);
        sda_lvl = (r_nxt.q >= 2'd2);
      end
      default: begin
        scl_lvl = (r_nxt.q == 2'd1) || (r_nxt.q == 2'd2);
        sda_lvl = (r_nxt.bitn == 4'h8) || (r_nxt.seg == seg_rdata) ||
                  r_nxt.shreg[7];
      end
    endcase
    r_nxt.scl_oe_n = scl_lvl;
    r_nxt.sda_oe_n = sda_lvl;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '{seg: seg_idle, q: 2'd0, bitn: 4'h0, qcnt: '0, rw: 1'b0,
             dev: 7'h00, regad: 8'h00, wdata: 8'h00, shreg: 8'h00,
             rdata: 8'h00, busy: 1'b0, done: 1'b0, ack_err: 1'b0,
             scl_oe_n: 1'b1, sda_oe_n: 1'b1, drv_lo: 1'b0};
    end else begin
      r <= r_nxt;
    end
  end

  assign bus.scl_o_h    = r.drv_lo;
  assign bus.scl_oe_n_h = r.scl_oe_n;
  assign bus.sda_o_h    = r.drv_lo;
  assign bus.sda_oe_n_h = r.sda_oe_n;
  assign busy           = r.busy;
  assign done           = r.done;
  assign rdata          = r.rdata;
  assign ack_err        = r.ack_err;
endmodule

// ===== test/smbus_checker.sv
`timescale 1ns/1ps
module smbus_checker (
  // Link clock and reset
  input wire logic       link_clk,
  input wire logic       srst,
  // Bus wires and device drive
  input wire logic       scl,
  input wire logic       sda,
  input wire logic       sda_o_d,
  input wire logic       sda_oe_n_d,
  // Device straps and status
  input wire logic [3:0] addr_sel,
  input wire logic       slave_en,
  input wire logic       bus_idle
);
  logic       scl_r;
  logic       sda_r;
  logic [7:0] nbit_r;
  logic [7:0] abyte_r;
  logic [8:0] high_r;

  default clocking @(posedge link_clk); endclocking
  default disable iff (srst);

  // Bit count since START, address byte and bus-high time
  always_ff @(posedge link_clk) begin
    scl_r <= scl;
    sda_r <= sda;
    if (scl && !scl_r && nbit_r < 8'h08) begin
      abyte_r <= {abyte_r[6:0], sda};
    end
    if (srst) begin
      nbit_r <= 8'h00;
      high_r <= 9'h000;
    end else begin
      if (scl && scl_r && sda_r && !sda) begin
        nbit_r <= 8'h00;
      end else if (scl && !scl_r) begin
        nbit_r <= nbit_r + 8'h01;
      end
      if (!(scl && sda)) begin
        high_r <= 9'h000;
      end else if (high_r != 9'h1ff) begin
        high_r <= high_r + 9'h001;
      end
    end
  end

  sequence start_s;
    scl && scl_r && sda_r && !sda;
  endsequence

  sequence rise_s;
    scl && !scl_r;
  endsequence

  od_low_a: assert property (!sda_oe_n_d |-> !sda_o_d)
    else $error("device drives sda high");
  dev_stable_a: assert property (scl && scl_r |-> $stable(sda_oe_n_d))
    else $error("device sda changed while scl high");
  host_edges_a: assert property (scl && scl_r && sda != sda_r |-> sda_oe_n_d && $past(sda_oe_n_d))
    else $error("sda edge with scl high while device drives");
  addr_ack_a: assert property (rise_s ##0 (nbit_r == 8'h08) |->
    sda == !(slave_en && abyte_r[7:1] == 7'h58 + {3'h0, addr_sel}))
    else $error("address acknowledge wrong");
  en_gate_a: assert property (!sda_oe_n_d |-> slave_en)
    else $error("device drives sda while disabled");
  quiet_addr_a: assert property (nbit_r inside {[8'h01:8'h07]} |-> sda_oe_n_d)
    else $error("device drives during address byte");
  idle_set_a: assert property (high_r == 9'h1a4 |-> bus_idle)
    else $error("bus idle not flagged");
  idle_quiet_a: assert property ($rose(bus_idle) |-> high_r >= 9'h01e)
    else $error("bus idle flagged too early");
  idle_end_a: assert property (start_s |-> ##[1:6] !bus_idle)
    else $error("bus idle kept after start");
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic       clk, srst, link_clk, lsrst, mode, cmd_valid, cmd_rw;
  logic [3:0] strap;
  logic [6:0] cmd_dev;
  logic [7:0] cmd_reg, cmd_wdata, rdata, reg_addr, wr_data, rd_data;
  logic       busy, done, ack_err, wr_stb, rd_stb, bus_idle, slave_en;
  logic [7:0] mem [256];
  logic [3:0] straps [4] = '{4'h0, 4'h5, 4'ha, 4'hf};
  int         failures, checked, cyc, wr_cnt, rd_cnt, ew, er;

  smbus_if smbus_if_inst ();
  smbus_host_end #(.QUARTER(20)) smbus_host_end_inst (.clk(clk), .srst(srst),
    .cmd_valid(cmd_valid), .cmd_rw(cmd_rw), .cmd_dev(cmd_dev), .cmd_reg(cmd_reg),
    .cmd_wdata(cmd_wdata), .busy(busy), .done(done), .rdata(rdata),
    .ack_err(ack_err), .bus(smbus_if_inst));
  smbus_device_end smbus_device_end_inst (.link_clk(link_clk), .srst(lsrst),
    .serial_mode_strap(mode), .addr_sel(strap), .bus(smbus_if_inst),
    .reg_addr(reg_addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_data(rd_data),
    .rd_stb(rd_stb), .bus_idle(bus_idle), .slave_en(slave_en));
  smbus_checker smbus_checker_inst (.link_clk(link_clk), .srst(lsrst),
    .scl(smbus_if_inst.scl), .sda(smbus_if_inst.sda), .sda_o_d(smbus_if_inst.sda_o_d),
    .sda_oe_n_d(smbus_if_inst.sda_oe_n_d), .addr_sel(strap), .slave_en(slave_en),
    .bus_idle(bus_idle));

  // Register file behind the device
  assign rd_data = mem[reg_addr];

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    link_clk = 1'b0;
    #7;
    forever #62.5 link_clk = ~link_clk;
  end

  always @(posedge link_clk) begin
    if (wr_stb === 1'b1) begin
      mem[reg_addr] <= wr_data;
      wr_cnt++;
    end
    if (rd_stb === 1'b1) begin
      rd_cnt++;
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic dev_reset(input logic m, input logic [3:0] s);
    @(posedge link_clk);
    lsrst <= 1'b1;
    mode <= m;
    strap <= s;
    repeat (5) @(posedge link_clk);
    lsrst <= 1'b0;
    repeat (4) @(posedge link_clk);
    chk("slave_en", {7'h00, m}, {7'h00, slave_en});
  endtask

  task automatic xfer(input logic rw, input logic [6:0] dev, input logic [7:0] rg,
                      input logic [7:0] wd);
    int n;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_rw <= rw;
    cmd_dev <= dev;
    cmd_reg <= rg;
    cmd_wdata <= wd;
    @(posedge clk);
    cmd_valid <= 1'b0;
    n = 0;
    @(negedge clk);
    chk("busy", 8'h01, {7'h00, busy});
    while (done !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    chk("done", 8'h01, {7'h00, done});
    // Bus-free gap, host inserts none
    repeat (240) @(posedge clk);
    chk("busy after done", 8'h00, {7'h00, busy});
  endtask

  task automatic round(input logic [3:0] s);
    logic [6:0] a;
    logic [7:0] rg;
    a = 7'h58 + {3'h0, s};
    rg = {s, 4'h3};
    dev_reset(1'b1, s);
    xfer(1'b0, a, rg, ~rg);
    ew++;
    chk("write ack_err", 8'h00, {7'h00, ack_err});
    chk("reg_addr", rg, reg_addr);
    chk("wr_data", ~rg, wr_data);
    chk("bus_idle", 8'h01, {7'h00, bus_idle});
    xfer(1'b1, a, rg, 8'h00);
    er++;
    chk("read data", ~rg, rdata);
    chk("read ack_err", 8'h00, {7'h00, ack_err});
    chk("idle after read", 8'h01, {7'h00, bus_idle});
    xfer(1'b1, a, rg + 8'h01, 8'h00);
    er++;
    chk("fresh data", (rg + 8'h01) ^ 8'h5a, rdata);
    xfer(1'b0, a ^ 7'h10, rg, 8'h00);
    chk("foreign ack_err", 8'h01, {7'h00, ack_err});
    chk("write count", ew[7:0], wr_cnt[7:0]);
    chk("read count", er[7:0], rd_cnt[7:0]);
  endtask

  initial begin
    srst = 1'b1;
    lsrst = 1'b1;
    mode = 1'b1;
    strap = 4'h0;
    cmd_valid = 1'b0;
    cmd_rw = 1'b0;
    cmd_dev = 7'h00;
    cmd_reg = 8'h00;
    cmd_wdata = 8'h00;
    for (int i = 0; i < 256; i++) begin
      mem[i] = i[7:0] ^ 8'h5a;
    end
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    foreach (straps[i]) begin
      round(straps[i]);
    end
    // Mode strap low: no answer at all
    dev_reset(1'b0, 4'h0);
    xfer(1'b0, 7'h58, 8'h01, 8'h77);
    chk("disabled ack_err", 8'h01, {7'h00, ack_err});
    chk("disabled writes", ew[7:0], wr_cnt[7:0]);
    repeat (600) @(posedge link_clk);
    chk("idle wires", 8'h03, {6'h00, smbus_if_inst.scl, smbus_if_inst.sda});
    tally_and_finish();
  end
endmodule
